// ---- src/udc_ctrl.v ----
`timescale 1ns/100ps
`default_nettype none
`include "udc_map.vh"

// =====================================================================
// Direction, disable and modem status control slice of one channel
module udc_ctrl (
    input  wire       clk_sys,
    input  wire       arst_n,
    // Channel register port
    input  wire [3:0] reg_addr,
    input  wire       reg_wr,
    input  wire       reg_rd,
    input  wire [7:0] reg_wdata,
    output reg  [7:0] reg_rdata_r,
    // Bits held by sibling registers
    input  wire       efr_enh_en,
    input  wire       ier_modem_int_en,
    // Modem pins, active low; modem interrupt output, active high
    input  wire       cts_n,
    input  wire       dsr_n,
    input  wire       ri_n,
    input  wire       cd_n,
    output wire       modem_int,
    // Transmit engine
    input  wire       tx_byte_load,
    input  wire       tx_last_stop_done,
    input  wire       tx_fifo_empty,
    input  wire       bit_tick,
    input  wire       flow_char_pending,
    input  wire       flow_char_sent,
    output wire       tx_shift_run,
    output wire       tx_flow_char_ok,
    output wire       sci_allowed,
    output reg        rs485_dir_r,
    output wire       auto_rs485_en,
    // Receive engine
    input  wire       rx_busy,
    input  wire       rx_char_done,
    output wire       rx_start_ok,
    output wire       rx_data_store_en,
    output wire       rx_flow_detect_en,
    output wire       rx_fifo_pop,
    // Feature control outputs
    output wire [1:0] trig_table_sel,
    output wire       rts_next_level_mode,
    output wire [3:0] rts_hyst_sel,
    output wire       irda_rx_inv
);

    // =====================================================================
    // Declarations
    wire [3:0] pin_sync;
    wire       cts_s;
    wire       dsr_s;
    wire       ri_s;
    wire       cd_s;
    reg  [3:0] pin_prev_r;
    reg  [3:0] delta_r;
    reg  [3:0] delta_nxt;
    wire [3:0] delta_evt;
    wire       stat_read;

    reg  [7:0] ctrl_r;
    reg  [7:0] scratch_r;
    reg  [7:0] feature_r;
    wire       ctrl_wr;

    wire [3:0] turn_delay;
    wire       tx_dis;
    wire       rx_dis;
    wire       tx_dis_mode;
    wire       rx_dis_mode;

    reg        tx_dis_d_r;
    reg        pend_keep_r;
    reg        pend_keep_nxt;
    reg        rx_halt_r;
    reg        rx_halt_nxt;

    reg        dir_nxt;
    wire       turn_start;
    wire       turn_done;

    reg  [7:0] rdata_nxt;

    // =====================================================================
    // Modem pin synchronisers
    udc_sync #(
        .WIDTH   (4),
        .RST_VAL (`UDC_RST_PIN_N)
    ) u_pin_sync (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .async_in ({cd_n, ri_n, dsr_n, cts_n}),
        .sync_out (pin_sync)
    );

    assign cts_s = pin_sync[0];
    assign dsr_s = pin_sync[1];
    assign ri_s  = pin_sync[2];
    assign cd_s  = pin_sync[3];

    // =====================================================================
    // Change detection on the synchronised pins
    // Ring change only on the pin rising, i.e. the end of a ring
    assign delta_evt[0] = cts_s ^ pin_prev_r[0];                      // R03
    assign delta_evt[1] = dsr_s ^ pin_prev_r[1];                      // R02
    assign delta_evt[2] = ri_s & ~pin_prev_r[2];                      // R01
    assign delta_evt[3] = cd_s ^ pin_prev_r[3];

    assign stat_read = reg_rd && (reg_addr == `UDC_OFF_MODEM_STAT);

    // Set wins over the read clear so an edge on the read cycle stays
    always @* begin
        delta_nxt = delta_r;
        if (stat_read) begin
            delta_nxt = 4'h0;                                         // R20
        end
        delta_nxt = delta_nxt | delta_evt;
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_prev_r <= `UDC_RST_PIN_N;
            delta_r    <= `UDC_RST_DELTA;                             // R01 R02 R03
        end else begin
            pin_prev_r <= pin_sync;
            delta_r    <= delta_nxt;
        end
    end

    assign modem_int = ier_modem_int_en & (|delta_r);                // R04

    // =====================================================================
    // Register writes
    // Control word is an enhanced register: lock it unless enabled
    assign ctrl_wr = reg_wr && (reg_addr == `UDC_OFF_MODEM_STAT) && efr_enh_en; // R06 R19

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_r    <= `UDC_RST_CTRL;                               // R08
            scratch_r <= `UDC_RST_SCRATCH;                            // R16
            feature_r <= `UDC_RST_FEATURE;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= reg_wdata;                                  // R05
            end
            if (reg_wr && (reg_addr == `UDC_OFF_SCRATCH)) begin
                scratch_r <= reg_wdata;                               // R16
            end
            if (reg_wr && (reg_addr == `UDC_OFF_FEATURE)) begin
                feature_r <= reg_wdata;
            end
        end
    end

    assign turn_delay  = ctrl_r[`UDC_CTL_DELAY_HI:`UDC_CTL_DELAY_LO]; // R05
    assign tx_dis      = ctrl_r[`UDC_CTL_TX_DIS];
    assign rx_dis      = ctrl_r[`UDC_CTL_RX_DIS];
    assign tx_dis_mode = ctrl_r[`UDC_CTL_TX_DIS_MODE];
    assign rx_dis_mode = ctrl_r[`UDC_CTL_RX_DIS_MODE];

    // =====================================================================
    // Register reads, data registered one cycle after the strobe
    always @* begin
        rdata_nxt = reg_rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                `UDC_OFF_MODEM_STAT: rdata_nxt = {~cd_s, ~ri_s, ~dsr_s, ~cts_s, delta_r};
                `UDC_OFF_SCRATCH:    rdata_nxt = scratch_r;
                `UDC_OFF_FEATURE:    rdata_nxt = feature_r;
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= 8'h00;
        end else begin
            reg_rdata_r <= rdata_nxt;
        end
    end

    // No receiver term here: the FIFO drains even while halted
    assign rx_fifo_pop = reg_rd && (reg_addr == `UDC_OFF_RX_HOLD);    // R13

    // =====================================================================
    // Transmitter disable
    // A flow character already waiting when the halt lands may still go
    always @* begin
        pend_keep_nxt = pend_keep_r;
        if (!tx_dis) begin
            pend_keep_nxt = 1'b0;
        end else if (!tx_dis_d_r) begin
            pend_keep_nxt = flow_char_pending;                        // R14
        end else if (flow_char_sent) begin
            pend_keep_nxt = 1'b0;                                     // R14
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_dis_d_r  <= 1'b0;
            pend_keep_r <= 1'b0;
        end else begin
            tx_dis_d_r  <= tx_dis;
            pend_keep_r <= pend_keep_nxt;
        end
    end

    assign tx_shift_run    = ~tx_dis;                                 // R08
    assign tx_flow_char_ok = ~tx_dis | tx_dis_mode | pend_keep_nxt;   // R14
    assign sci_allowed     = ~tx_dis;                                 // R09

    // =====================================================================
    // Receiver disable
    // Halt takes hold only between characters so a running one completes
    always @* begin
        rx_halt_nxt = rx_halt_r;
        if (!rx_dis) begin
            rx_halt_nxt = 1'b0;                                       // R11
        end else if (!rx_busy || rx_char_done) begin
            rx_halt_nxt = 1'b1;                                       // R10
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_halt_r <= 1'b0;
        end else begin
            rx_halt_r <= rx_halt_nxt;
        end
    end

    // Re-enable is immediate; a toggling line may feed garbage then
    assign rx_start_ok       = ~rx_dis & ~rx_halt_r;                  // R10 R11
    assign rx_data_store_en  = ~rx_halt_r;                            // R10 R15
    assign rx_flow_detect_en = ~rx_halt_r | rx_dis_mode;              // R15

    // =====================================================================
    // Automatic RS-485 direction control
    assign auto_rs485_en = feature_r[`UDC_FC_RS485_EN];

    // Timer only started in auto mode, reloads cancel a pending drop
    assign turn_start = auto_rs485_en & tx_last_stop_done & tx_fifo_empty
                        & ~tx_byte_load;                              // R07
    udc_turn_timer u_turn_timer (
        .clk_sys    (clk_sys),
        .arst_n     (arst_n),
        .start      (turn_start),
        .cancel     (tx_byte_load),
        .delay_bits (turn_delay),                                     // R05
        .bit_tick   (bit_tick),
        .done_r     (turn_done)
    );

    always @* begin
        dir_nxt = rs485_dir_r;
        if (!auto_rs485_en) begin
            dir_nxt = 1'b0;                                           // R07
        end else if (tx_byte_load) begin
            dir_nxt = 1'b1;                                           // R18
        end else if (turn_done) begin
            dir_nxt = 1'b0;                                           // R18
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rs485_dir_r <= 1'b0;
        end else begin
            rs485_dir_r <= dir_nxt;
        end
    end

    // =====================================================================
    // Trigger table and hysteresis selection
    assign trig_table_sel      = feature_r[`UDC_FC_TABLE_HI:`UDC_FC_TABLE_LO]; // R17
    assign rts_next_level_mode = (trig_table_sel != `UDC_TABLE_D);    // R17
    assign rts_hyst_sel        = feature_r[`UDC_FC_HYST_HI:`UDC_FC_HYST_LO];
    assign irda_rx_inv         = feature_r[`UDC_FC_IRDA_INV];

endmodule // udc_ctrl

`default_nettype wire

// ---- src/udc_map.vh ----
// Functional notes
// R01: Ring change flag sets only on ring input low-to-high, marking ring end; resets zero.
// R02: Data-set-ready change flag sets on any change since last status read; resets zero.
// R03: Clear-to-send change flag sets on any change since last status read; resets zero.
// R04: Any change flag set with modem interrupt enable raises the modem interrupt.
// R05: Control bits 7:4 give 0..15 bit times from last stop bit to direction change.
// R06: Turnaround delay writes only land while the enhanced enable bit is one.
// R07: Turnaround delay applies only with automatic RS-485 direction control enabled.
// R08: Transmitter disable halts the shift register; clearing resumes queued bytes; resets zero.
// R09: Send-character-immediate works only while transmitter disable is zero.
// R10: Receiver disable finishes a character in progress, then accepts none.
// R11: After receiver re-enable on an idle line the next character is received normally.
// R12: Software should clear receiver disable only while the receive line idles.
// R13: Receive FIFO stays readable whether or not the receiver is disabled.
// R14: Transmitter disabled: mode 0 sends only a pending flow character, mode 1 keeps sending.
// R15: Receiver disabled: mode 0 ignores everything, mode 1 still acts on xon/xoff.
// R16: Eight-bit read/write scratch pad, all ones after reset.
// R17: Two-bit field selects trigger table; first three use next level above and below.
// R18: Direction drops after last stop bit, rises when a byte loads before start bit.
// R19: Enhanced enable gates writes to the whole control register; clearing it latches.
// R20: Reading modem status clears all change flags.
`ifndef UDC_MAP_VH
`define UDC_MAP_VH

// =====================================================================
// Register offsets on the channel register port
`define UDC_OFF_RX_HOLD      4'h0
`define UDC_OFF_MODEM_STAT   4'h6
`define UDC_OFF_SCRATCH      4'h7
`define UDC_OFF_FEATURE      4'h8

// =====================================================================
// Control register fields (write side of the modem status offset)
`define UDC_CTL_DELAY_HI     7
`define UDC_CTL_DELAY_LO     4
`define UDC_CTL_TX_DIS       3
`define UDC_CTL_RX_DIS       2
`define UDC_CTL_TX_DIS_MODE  1
`define UDC_CTL_RX_DIS_MODE  0

// =====================================================================
// Feature control fields
`define UDC_FC_TABLE_HI      7
`define UDC_FC_TABLE_LO      6
`define UDC_FC_RS485_EN      5
`define UDC_FC_IRDA_INV      4
`define UDC_FC_HYST_HI       3
`define UDC_FC_HYST_LO       0
`define UDC_TABLE_D          2'h3

// =====================================================================
// Reset values
`define UDC_RST_CTRL         8'h00
`define UDC_RST_SCRATCH      8'hff
`define UDC_RST_FEATURE      8'h00
`define UDC_RST_PIN_N        4'hf
`define UDC_RST_DELTA        4'h0

`endif

// ---- src/udc_sync.v ----
`timescale 1ns/100ps
`default_nettype none
`include "udc_map.vh"

// =====================================================================
// Two-stage synchroniser, one generate lane per bit
module udc_sync #(
    parameter       WIDTH   = 4,
    parameter [3:0] RST_VAL = `UDC_RST_PIN_N
) (
    input  wire             clk_sys,
    input  wire             arst_n,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_lane
            reg meta_r;
            reg stab_r;
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    meta_r <= RST_VAL[i];
                    stab_r <= RST_VAL[i];
                end else begin
                    meta_r <= async_in[i];
                    stab_r <= meta_r;
                end
            end
            assign sync_out[i] = stab_r;
        end
    endgenerate

endmodule // udc_sync

`default_nettype wire

// ---- src/udc_turn_timer.v ----
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Counts whole bit times after the last stop bit
module udc_turn_timer (
    input  wire       clk_sys,
    input  wire       arst_n,
    input  wire       start,
    input  wire       cancel,
    input  wire [3:0] delay_bits,
    input  wire       bit_tick,
    output reg        done_r
);

    reg [3:0] cnt_r;
    reg       busy_r;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= 4'h0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (cancel) begin
                busy_r <= 1'b0;
            end else if (start) begin
                if (delay_bits == 4'h0) begin
                    done_r <= 1'b1;
                    busy_r <= 1'b0;
                end else begin
                    cnt_r  <= delay_bits;
                    busy_r <= 1'b1;
                end
            end else if (busy_r && bit_tick) begin
                if (cnt_r == 4'h1) begin
                    done_r <= 1'b1;
                    busy_r <= 1'b0;
                end
                cnt_r <= cnt_r - 4'h1;
            end
        end
    end

endmodule // udc_turn_timer

`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Self-checking bench of the control slice
module tb_top;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic       reg_wr = 1'b0;
    logic       reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata_r;
    logic       efr_enh_en = 1'b0;
    logic       ier_modem_int_en = 1'b0;
    logic       cts_n, dsr_n, ri_n, cd_n, modem_int;
    logic       tx_byte_load = 1'b0;
    logic       tx_last_stop_done = 1'b0;
    logic       tx_fifo_empty = 1'b1;
    logic       bit_tick = 1'b0;
    logic       flow_char_pending = 1'b0;
    logic       flow_char_sent = 1'b0;
    logic       tx_shift_run, tx_flow_char_ok, sci_allowed, rs485_dir_r, auto_rs485_en;
    logic       rx_busy = 1'b0;
    logic       rx_char_done = 1'b0;
    logic       rx_start_ok, rx_data_store_en, rx_flow_detect_en, rx_fifo_pop;
    logic [1:0] trig_table_sel;
    logic       rts_next_level_mode, irda_rx_inv;
    logic [3:0] rts_hyst_sel;
    int         mismatches = 0;
    int         samples_checked = 0;
    logic [3:0] pv [6] = '{4'he, 4'hc, 4'h8, 4'hc, 4'h4, 4'h5};
    logic [7:0] sv [6] = '{8'h11, 8'h32, 8'h70, 8'h34, 8'hb8, 8'ha1};
    logic [5:0] iv = 6'b111010;

    always #5 clk_sys = ~clk_sys;

    udc_ctrl dut (.*);
    udc_modem_model modem (.*);

    // =====================================================================
    // Tasks
    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk({7'h0, got}, {7'h0, exp});
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_r, e);
    endtask

    // Load then last stop bit, then d ticks before the drop
    task automatic turn(input int d);
        @(posedge clk_sys) tx_byte_load <= 1'b1;
        @(posedge clk_sys) tx_byte_load <= 1'b0;
        #1 chk1(rs485_dir_r, 1'b1);
        @(posedge clk_sys) tx_last_stop_done <= 1'b1;
        @(posedge clk_sys) tx_last_stop_done <= 1'b0;
        repeat (d) begin
            repeat (2) @(posedge clk_sys);
            #1 chk1(rs485_dir_r, 1'b1);
            @(posedge clk_sys) bit_tick <= 1'b1;
            @(posedge clk_sys) bit_tick <= 1'b0;
        end
        repeat (2) @(posedge clk_sys);
        #1 chk1(rs485_dir_r, 1'b0);
    endtask

    // =====================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(4'h7, 8'hff);
        rd(4'h8, 8'h00);
        rd(4'h6, 8'h00);
        rd(4'h5, 8'h00);
        chk1(tx_shift_run, 1'b1);
        wr(4'h7, 8'h5a);
        rd(4'h7, 8'h5a);
        for (int i = 0; i < 6; i++) begin
            modem.pins(pv[i]);
            repeat (5) @(posedge clk_sys);
            #1 chk1(modem_int, iv[i]);
            if (i == 0) begin
                @(posedge clk_sys) ier_modem_int_en <= 1'b1;
                #1 chk1(modem_int, 1'b1);
            end
            rd(4'h6, sv[i]);
            if (i == 0)
                rd(4'h6, 8'h10);
            chk1(modem_int, 1'b0);
        end
        wr(4'h6, 8'h08);
        chk1(tx_shift_run, 1'b1);
        @(posedge clk_sys) efr_enh_en <= 1'b1;
        flow_char_pending <= 1'b1;
        wr(4'h6, 8'h08);
        chk1(tx_shift_run, 1'b0);
        chk1(sci_allowed, 1'b0);
        chk1(tx_flow_char_ok, 1'b1);
        @(posedge clk_sys) flow_char_pending <= 1'b0;
        flow_char_sent <= 1'b1;
        @(posedge clk_sys) flow_char_sent <= 1'b0;
        @(posedge clk_sys);
        #1 chk1(tx_flow_char_ok, 1'b0);
        wr(4'h6, 8'h0a);
        chk1(tx_flow_char_ok, 1'b1);
        // Character in flight must finish before the halt
        @(posedge clk_sys) rx_busy <= 1'b1;
        wr(4'h6, 8'h04);
        chk1(tx_shift_run, 1'b1);
        chk1(rx_start_ok, 1'b0);
        chk1(rx_data_store_en, 1'b1);
        @(posedge clk_sys) rx_char_done <= 1'b1;
        rx_busy <= 1'b0;
        @(posedge clk_sys) rx_char_done <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk1(rx_data_store_en, 1'b0);
        chk1(rx_flow_detect_en, 1'b0);
        wr(4'h6, 8'h05);
        chk1(rx_flow_detect_en, 1'b1);
        @(posedge clk_sys) reg_addr <= 4'h0;
        reg_rd <= 1'b1;
        #1 chk1(rx_fifo_pop, 1'b1);
        @(posedge clk_sys) reg_rd <= 1'b0;
        wr(4'h6, 8'h00);
        repeat (2) @(posedge clk_sys);
        #1 chk1(rx_data_store_en, 1'b1);
        chk1(rx_start_ok, 1'b1);
        wr(4'h8, 8'h1b);
        chk({4'h0, rts_hyst_sel}, 8'h0b);
        chk1(irda_rx_inv, 1'b1);
        for (int t = 0; t < 4; t++) begin
            wr(4'h8, {t[1:0], 6'h20});
            chk({6'h0, trig_table_sel}, t[7:0]);
            chk1(rts_next_level_mode, t != 3);
        end
        rd(4'h8, 8'he0);
        chk1(irda_rx_inv, 1'b0);
        chk1(auto_rs485_en, 1'b1);
        // Queue not yet empty at the stop bit: driver must stay on
        @(posedge clk_sys) tx_byte_load <= 1'b1;
        tx_fifo_empty <= 1'b0;
        @(posedge clk_sys) tx_byte_load <= 1'b0;
        tx_last_stop_done <= 1'b1;
        @(posedge clk_sys) tx_last_stop_done <= 1'b0;
        tx_fifo_empty <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk1(rs485_dir_r, 1'b1);
        for (int d = 0; d < 16; d += 5) begin
            wr(4'h6, {d[3:0], 4'h0});
            turn(d);
        end
        @(posedge clk_sys) efr_enh_en <= 1'b0;
        wr(4'h6, 8'h00);
        turn(15);
        wr(4'h8, 8'h00);
        @(posedge clk_sys) tx_byte_load <= 1'b1;
        @(posedge clk_sys) tx_byte_load <= 1'b0;
        #1 chk1(rs485_dir_r, 1'b0);
        close_out();
    end

    // Whole run is under a thousand cycles; allow ten thousand
    initial begin
        #100000;
        mismatches++;
        close_out();
    end
endmodule // tb_top

bind udc_ctrl udc_ctrl_monitor mon (.*);

`default_nettype wire

// ---- verif/udc_ctrl_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Port checks of the control slice
module udc_ctrl_monitor (
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic [3:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       efr_enh_en,
    input wire logic       ier_modem_int_en,
    input wire logic       modem_int,
    input wire logic       tx_byte_load,
    input wire logic       tx_shift_run,
    input wire logic       sci_allowed,
    input wire logic       rs485_dir_r,
    input wire logic       auto_rs485_en,
    input wire logic       rx_start_ok,
    input wire logic       rx_data_store_en,
    input wire logic       rx_flow_detect_en,
    input wire logic       rx_fifo_pop,
    input wire logic       rx_busy,
    input wire logic       rx_char_done,
    input wire logic [1:0] trig_table_sel,
    input wire logic       rts_next_level_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    mask_int_a: assert property (!ier_modem_int_en |-> !modem_int)
        else $error("modem interrupt while masked");
    gate_wr_a: assert property (reg_wr && reg_addr == 4'h6 && !efr_enh_en
        |=> $stable(tx_shift_run)) else $error("gated write landed");
    tx_dis_a: assert property (reg_wr && reg_addr == 4'h6 && efr_enh_en
        |=> tx_shift_run == !$past(reg_wdata[3])) else $error("tx halt wrong");
    sci_gate_a: assert property (sci_allowed == tx_shift_run)
        else $error("immediate send not tied to tx enable");
    dir_up_a: assert property (tx_byte_load && auto_rs485_en |=> rs485_dir_r)
        else $error("direction not raised on load");
    dir_off_a: assert property (!auto_rs485_en && !$past(auto_rs485_en)
        |-> !rs485_dir_r) else $error("direction driven while auto off");
    rx_halt_a: assert property (!rx_data_store_en |-> !rx_start_ok)
        else $error("receiver starts while halted");
    rx_finish_a: assert property (rx_busy && !rx_char_done && rx_data_store_en
        |=> rx_data_store_en) else $error("receiver halted mid character");
    rx_flow_a: assert property (rx_data_store_en |-> rx_flow_detect_en)
        else $error("flow detect off while receiving");
    fifo_pop_a: assert property (rx_fifo_pop == (reg_rd && reg_addr == 4'h0))
        else $error("receive fifo pop wrong");
    table_sel_a: assert property (rts_next_level_mode == (trig_table_sel != 2'h3))
        else $error("next level mode wrong");
    scratch_rw_a: assert property (reg_wr && reg_addr == 4'h7 ##2 reg_rd && reg_addr == 4'h7
        |=> reg_rdata_r == $past(reg_wdata, 3)) else $error("scratch readback wrong");

    cover property ($rose(rs485_dir_r));
    cover property ($fell(rx_data_store_en));
    cover property ($rose(modem_int));
endmodule // udc_ctrl_monitor

`default_nettype wire

// ---- verif/udc_modem_model.sv ----
`timescale 1ns/100ps
`default_nettype none

// =====================================================================
// Modem pins seen from the far side, idle high
module udc_modem_model (
    input  wire logic clk_sys,
    output var logic  cts_n,
    output var logic  dsr_n,
    output var logic  ri_n,
    output var logic  cd_n
);
    initial {cd_n, ri_n, dsr_n, cts_n} = 4'hf;

    // Pins move just after an edge, never on it
    task automatic pins(input logic [3:0] v);
        @(posedge clk_sys);
        {cd_n, ri_n, dsr_n, cts_n} <= v;
    endtask
endmodule // udc_modem_model

`default_nettype wire
